// ### include/cwr_map.vh
// Overview of operation
// - Programmed bit reads 0, unprogrammed reads 1
// - Configuration word lives at location 2007h
// - Config space reachable only in programming mode
// - Code-protect field selects protected address range
// - Watchdog disabled only by configuration word
// - Watchdog clocked by its own RC tick
// - Start-up timer holds reset until oscillator stable
// - Power-up delay holds reset, power-up only
// - Sleep left on reset, watchdog, or interrupt
// - Power-on delay, then power-up timer, then start-up
// - RC with power-up timer off: no time-out
// - Time-outs run regardless of master clear pin
// - Watchdog enable bit cleared disables watchdog until the next power-on reset
// - Watchdog time-out resets, or wakes from sleep
`ifndef CWR_MAP_VH
`define CWR_MAP_VH
`define CWR_CFG_ADDR 14'h2007
`define CWR_CFG_SPACE_LO 14'h2000
`define CWR_CFG_RESET 14'h3fff
`define CWR_BIT_OSC0 0
`define CWR_BIT_OSC1 1
`define CWR_BIT_WDTEN 2
`define CWR_BIT_PWRTEN_N 3
`define CWR_BIT_CP0 4
`define CWR_BIT_CP1 5
`define CWR_BIT_BOREN 6
`define CWR_OSC_RC 2'h3
`define CWR_OSC_HS 2'h2
`define CWR_OSC_XT 2'h1
`define CWR_OSC_LP 2'h0
`define CWR_CP_NONE 2'h3
`define CWR_CP_UPPER 2'h2
`define CWR_CP_FROM200 2'h1
`define CWR_CP_ALL 2'h0
`define CWR_CP_UPPER_LO 11'h400
`define CWR_CP_MID_LO 11'h200
`define CWR_POR_US 10
`define CWR_POR_CYC ((`CWR_POR_US * 20 + 0) > 0 ? (`CWR_POR_US * 20) : 1)
`define CWR_POWERUP_DELAY_TIMER_US 72000
`define CWR_POWERUP_DELAY_TIMER_CYC (`CWR_POWERUP_DELAY_TIMER_US * 20)
`define CWR_OST_OSC_CYC 1024
`define CWR_WDT_TICKS 18
`endif

// ### core/cwr_counter.v
`timescale 1ns/1ps
// Down-counter delay: busy held high from start until count expires
module cwr_counter #(
  parameter WIDTH = 24
) (
  input wire clock, // System clock
  input wire rst_n, // Async reset, active low
  input wire start, // Load and run
  input wire step, // Count enable
  input wire [WIDTH-1:0] load, // Cycles to wait
  output reg busy // High while counting
);
  reg [WIDTH-1:0] count; // Remaining steps

  // Load on start, count down on each enabled step
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
      busy <= 1'b0;
    end else if (start) begin
      count <= load;
      busy <= (load != {WIDTH{1'b0}});
    end else if (busy && step) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      if (count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

// ### core/cwr_watchdog.v
`timescale 1ns/1ps
// Watchdog counting ticks of its own RC oscillator
module cwr_watchdog #(
  parameter TICKS = 18 // RC ticks to time-out
) (
  input wire clock, // System clock
  input wire rst_n, // Async reset, active low
  input wire enable, // From configuration word only
  input wire rc_tick, // One pulse per RC oscillator period
  input wire clear, // Clear-watchdog or sleep entry
  output reg timeout // One-cycle time-out pulse
);
  reg [7:0] count; // RC periods since last clear

  // Counts only RC ticks, so a stopped main oscillator cannot stall it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (!enable || clear) begin
        count <= 8'h00;
      end else if (rc_tick) begin
        if (count == TICKS[7:0] - 8'h01) begin
          count <= 8'h00;
          timeout <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end
endmodule

// ### core/cwr_top.v
`timescale 1ns/1ps
`include "cwr_map.vh"
// Configuration decode and power-up time-out sequencer
module cwr_top #(
  parameter POR_CYC = `CWR_POR_CYC, // Power-on detect delay cycles
  parameter POWERUP_DELAY_TIMER_CYC = `CWR_POWERUP_DELAY_TIMER_CYC, // Power-up delay cycles
  parameter OST_CYC = `CWR_OST_OSC_CYC, // Oscillator periods to stable
  parameter WDT_TICKS = `CWR_WDT_TICKS // Watchdog RC periods
) (
  input wire clock, // 20 MHz clock
  input wire rst_n, // Power-on pulse, active low
  input wire master_clear_pin_n, // External reset pin, active low
  input wire prog_mode, // Device in programming mode
  input wire [13:0] prog_addr, // Programmer address
  input wire [13:0] prog_wdata, // Programmer write data
  input wire prog_wr, // Programmer write strobe
  input wire prog_rd, // Programmer read strobe
  output reg [13:0] prog_rdata, // Read data, cycle after strobe
  input wire osc_tick, // One pulse per oscillator period
  input wire wdt_rc_tick, // One pulse per watchdog RC period
  input wire brownout_low, // Supply below trip point
  input wire sleep_req, // Core enters sleep
  input wire clrwdt, // Clear watchdog instruction
  input wire irq_wake, // Interrupt wake-up request
  input wire [10:0] fetch_addr, // Address to test protection
  output reg device_reset_n, // Core held in reset, active low
  output reg sleeping, // Core in sleep
  output reg wdt_wake, // Watchdog wake-up pulse
  output reg code_protected, // fetch_addr is protected
  output reg [1:0] osc_mode, // Decoded oscillator select
  output reg brownout_reset, // Brown-out reset active
  output reg timeout_busy // Time-out sequence running
);
  localparam S_POR = 4'h1; // Power-on detect delay
  localparam S_POWERUP_DELAY_TIMER = 4'h2; // Power-up delay timer
  localparam S_OST = 4'h4; // Oscillator start-up timer
  localparam S_DONE = 4'h8; // Time-outs expired

  reg [13:0] cfg_word; // Stored configuration word, erased = ones
  reg [3:0] state; // Sequencer state
  reg [3:0] next_state; // Next sequencer state
  reg start_por; // Load power-on delay
  reg start_powerup_delay_timer; // Load power-up delay
  reg start_ost; // Load start-up count
  reg started; // Power-on delay already kicked
  reg wdt_reset; // Watchdog reset request
  wire por_busy; // Power-on delay running
  wire powerup_delay_timer_busy; // Power-up delay running
  wire ost_busy; // Start-up timer running
  wire wdt_timeout; // Watchdog expired
  wire [1:0] osc_sel; // Oscillator field
  wire [1:0] cp_sel; // Code-protect field
  wire wdt_en; // Watchdog enable bit
  wire boren; // Brown-out enable
  wire powerup_delay_timer_on; // Effective power-up timer enable

  // Field decode: stored level is the meaning, 0 = programmed
  assign osc_sel = {cfg_word[`CWR_BIT_OSC1], cfg_word[`CWR_BIT_OSC0]};
  assign cp_sel = {cfg_word[`CWR_BIT_CP1], cfg_word[`CWR_BIT_CP0]};
  assign wdt_en = cfg_word[`CWR_BIT_WDTEN];
  assign boren = cfg_word[`CWR_BIT_BOREN];
  // Brown-out enable forces the delay timer on despite its own bit
  assign powerup_delay_timer_on = boren | ~cfg_word[`CWR_BIT_PWRTEN_N];

  // Protection test for the 2K variant
  function is_protected;
    input [1:0] cp;
    input [10:0] addr;
    begin
      case (cp)
        `CWR_CP_NONE: is_protected = 1'b0;
        `CWR_CP_UPPER: is_protected = (addr >= `CWR_CP_UPPER_LO);
        `CWR_CP_FROM200: is_protected = (addr >= `CWR_CP_MID_LO);
        default: is_protected = 1'b1;
      endcase
    end
  endfunction

  // Configuration word: reachable only in programming mode
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_word <= `CWR_CFG_RESET;
      prog_rdata <= 14'h0000;
    end else begin
      prog_rdata <= 14'h0000;
      if (prog_mode && prog_wr && prog_addr == `CWR_CFG_ADDR) begin
        cfg_word <= cfg_word & prog_wdata; // Program only clears bits
      end
      if (prog_mode && prog_rd && prog_addr == `CWR_CFG_ADDR) begin
        prog_rdata <= cfg_word;
      end
    end
  end

  // Sequencer transitions; pin does not gate the counters
  always @* begin
    next_state = state;
    start_powerup_delay_timer = 1'b0;
    start_ost = 1'b0;
    case (state)
      S_POR: begin
        // Wait for the kick cycle, else a stale idle busy starts the next timer early
        if (started && !start_por && !por_busy) begin
          if (powerup_delay_timer_on) begin
            next_state = S_POWERUP_DELAY_TIMER;
            start_powerup_delay_timer = 1'b1;
          end else if (osc_sel != `CWR_OSC_RC) begin
            next_state = S_OST;
            start_ost = 1'b1;
          end else begin
            next_state = S_DONE;
          end
        end
      end
      S_POWERUP_DELAY_TIMER: begin
        if (!start_powerup_delay_timer && !powerup_delay_timer_busy) begin
          if (osc_sel != `CWR_OSC_RC) begin
            next_state = S_OST;
            start_ost = 1'b1;
          end else begin
            next_state = S_DONE;
          end
        end
      end
      S_OST: begin
        if (!ost_busy) begin
          next_state = S_DONE;
        end
      end
      S_DONE: next_state = S_DONE;
      default: next_state = S_POR;
    endcase
  end

  // State and kick of the power-on delay
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_POR;
      started <= 1'b0;
      start_por <= 1'b0;
    end else begin
      start_por <= !started;
      started <= 1'b1;
      if (started && !start_por) begin
        state <= next_state;
      end
    end
  end

  cwr_counter #(.WIDTH(8)) u_por (
    .clock(clock),
    .rst_n(rst_n),
    .start(start_por),
    .step(1'b1),
    .load(POR_CYC[7:0]),
    .busy(por_busy)
  );

  cwr_counter #(.WIDTH(24)) u_powerup_delay_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(start_powerup_delay_timer),
    .step(1'b1),
    .load(POWERUP_DELAY_TIMER_CYC[23:0]),
    .busy(powerup_delay_timer_busy)
  );

  // Start-up count is in oscillator periods
  cwr_counter #(.WIDTH(24)) u_ost (
    .clock(clock),
    .rst_n(rst_n),
    .start(start_ost),
    .step(osc_tick),
    .load(OST_CYC[23:0]),
    .busy(ost_busy)
  );

  cwr_watchdog #(.TICKS(WDT_TICKS)) u_wdt (
    .clock(clock),
    .rst_n(rst_n),
    .enable(wdt_en),
    .rc_tick(wdt_rc_tick),
    .clear(clrwdt | (sleep_req & ~sleeping)),
    .timeout(wdt_timeout)
  );

  // Outputs, sleep and watchdog action
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      device_reset_n <= 1'b0;
      sleeping <= 1'b0;
      wdt_wake <= 1'b0;
      wdt_reset <= 1'b0;
      code_protected <= 1'b1;
      osc_mode <= `CWR_OSC_RC;
      brownout_reset <= 1'b0;
      timeout_busy <= 1'b1;
    end else begin
      wdt_wake <= 1'b0;
      wdt_reset <= wdt_timeout & ~sleeping;
      osc_mode <= osc_sel;
      code_protected <= is_protected(cp_sel, fetch_addr);
      brownout_reset <= boren & brownout_low;
      timeout_busy <= (state != S_DONE);
      // Pin held low past expiry releases execution at once
      device_reset_n <= (state == S_DONE) && master_clear_pin_n && !wdt_reset
                        && !(boren & brownout_low) && !prog_mode;
      if (!master_clear_pin_n || !device_reset_n) begin
        sleeping <= 1'b0;
      end else if (sleeping && wdt_timeout) begin
        sleeping <= 1'b0;
        wdt_wake <= 1'b1;
      end else if (sleeping && irq_wake) begin
        sleeping <= 1'b0;
      end else if (sleep_req) begin
        sleeping <= 1'b1;
      end
    end
  end
endmodule

// ### verif/cwr_monitor.sv
`timescale 1ns/1ps
`include "cwr_map.vh"
// Port checker for the decode and time-out sequencer
module cwr_monitor (
  input wire clock, // System clock
  input wire rst_n, // Power-on pulse
  input wire master_clear_pin_n, // Reset pin
  input wire prog_mode, // Programming mode
  input wire [13:0] prog_addr, // Programmer address
  input wire prog_rd, // Read strobe
  input wire [13:0] prog_rdata, // Read data
  input wire brownout_low, // Supply low
  input wire device_reset_n, // Core reset
  input wire timeout_busy, // Sequence running
  input wire brownout_reset, // Brown-out reset
  input wire sleeping, // Core asleep
  input wire wdt_wake // Wake pulse
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Pin let go once the time-outs are over
  sequence s_pin_up;
    $rose(master_clear_pin_n) && !timeout_busy && !prog_mode && !brownout_low;
  endsequence
  property p_rd_refused;
    prog_rd && (!prog_mode || prog_addr != `CWR_CFG_ADDR) |=> prog_rdata == 14'h0;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("refused read gave data");
  property p_rd_idle;
    !prog_rd |=> prog_rdata == 14'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
  property p_bor_off;
    !brownout_low [*2] |-> !brownout_reset;
  endproperty
  a_bor_off: assert property (p_bor_off) else $error("brown-out with good supply");
  property p_busy_hold;
    timeout_busy |-> !device_reset_n;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("core ran during time-out");
  property p_pin_hold;
    !master_clear_pin_n |=> !device_reset_n;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("core ran with pin low");
  property p_pin_go;
    s_pin_up |-> ##[1:2] device_reset_n;
  endproperty
  a_pin_go: assert property (p_pin_go) else $error("late start after pin");
  property p_wake_sleep;
    wdt_wake |-> $past(sleeping) ##1 !sleeping;
  endproperty
  a_wake_sleep: assert property (p_wake_sleep) else $error("wake not from sleep");
  property p_wake_once;
    wdt_wake |=> !wdt_wake;
  endproperty
  a_wake_once: assert property (p_wake_once) else $error("wake pulse too long");
endmodule
bind cwr_top cwr_monitor mon (.*);

// ### verif/cwr_partner.sv
`timescale 1ns/1ps
// Programmer and reset pin driver facing the device
module cwr_partner (
  input wire clock, // System clock
  output logic master_clear_pin_n = 1'b0, // Reset pin, starts low
  output logic prog_mode = 1'b0, // Programming mode
  output logic [13:0] prog_addr = 14'h0, // Address
  output logic [13:0] prog_wdata = 14'h0, // Write data
  output logic prog_wr = 1'b0, // Write strobe
  output logic prog_rd = 1'b0, // Read strobe
  input wire [13:0] prog_rdata // Read data
);
  // Config space only reachable while this is held
  task automatic set_mode(input logic m);
    @(posedge clock);
    prog_mode <= m;
  endtask
  // Idle lines show the inverse so stale values never match
  task automatic word_write(input logic [13:0] a, input logic [13:0] d);
    @(posedge clock);
    prog_addr <= a;
    prog_wdata <= d;
    prog_wr <= 1'b1;
    @(posedge clock);
    prog_wr <= 1'b0;
    prog_addr <= ~a;
    prog_wdata <= ~d;
  endtask
  // Data taken inside the cycle after the strobe
  task automatic word_read(input logic [13:0] a, output logic [13:0] d);
    @(posedge clock);
    prog_addr <= a;
    prog_rd <= 1'b1;
    @(posedge clock);
    prog_rd <= 1'b0;
    prog_addr <= ~a;
    #1 d = prog_rdata;
  endtask
  // Prompt or slow pin move
  task automatic pin(input logic lvl, input int n);
    repeat (n) @(posedge clock);
    @(posedge clock);
    master_clear_pin_n <= lvl;
  endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "cwr_map.vh"
// Self-checking bench for the sequencer
module tb_top;
  localparam int POR = 8; // Shortened power-on delay
  localparam int POWERUP_DELAY_TIMER = 40; // Shortened power-up delay
  localparam int OSC_STARTUP_TIMER = 8; // Shortened start-up count
  logic clock = 1'b0; // System clock
  logic rst_n = 1'b0; // Power-on pulse
  logic osc_tick = 1'b0; // Every fourth cycle
  logic wdt_rc_tick = 1'b0; // Watchdog RC pulse
  logic brownout_low = 1'b0; // Supply low
  logic sleep_req = 1'b0; // Sleep entry
  logic clrwdt = 1'b0; // Clear watchdog
  logic irq_wake = 1'b0; // Interrupt wake
  logic [10:0] fetch_addr = 11'h0; // Protection probe
  wire master_clear_pin_n, prog_mode, prog_wr, prog_rd;
  wire [13:0] prog_addr, prog_wdata, prog_rdata;
  wire device_reset_n, sleeping, wdt_wake, code_protected, brownout_reset, timeout_busy;
  wire [1:0] osc_mode;
  logic [13:0] tab[6] = '{14'h3fbf, 14'h3fa7, 14'h3fdf, 14'h3f8d, 14'h3fbe, 14'h3fbc}; // Words under test
  int err_count = 0, checked = 0, cyc = 0, t_on = 0, t_done = 0, n_rst = 0, n_wake = 0;
  cwr_partner pm (.*);
  cwr_top #(.POR_CYC(POR), .POWERUP_DELAY_TIMER_CYC(POWERUP_DELAY_TIMER), .OST_CYC(OSC_STARTUP_TIMER), .WDT_TICKS(3)) dut (.*);
  initial forever #25 clock = ~clock;
  // Cycle count, hang guard, oscillator ticks, event tallies
  always @(posedge clock) begin
    cyc <= cyc + 1;
    osc_tick <= (cyc % 4 == 3);
    if (device_reset_n === 1'b0) n_rst++;
    if (wdt_wake === 1'b1) n_wake++;
    if (cyc == 8000) begin
      err_count++;
      results();
    end
  end
  // Stamps of power-on release and sequence end
  always @(posedge rst_n) t_on = cyc;
  always @(negedge timeout_busy) t_done = cyc;
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One-cycle pulse on sleep, clear and interrupt inputs
  task automatic pls(input logic [2:0] m);
    {sleep_req, clrwdt, irq_wake} <= m;
    tick(1);
    {sleep_req, clrwdt, irq_wake} <= 3'h0;
    tick(1);
  endtask
  // RC ticks one core cycle wide, one every four core clock cycles
  task automatic rc(input int n);
    repeat (n) begin
      wdt_rc_tick <= 1'b1;
      tick(1);
      wdt_rc_tick <= 1'b0;
      tick(3);
    end
  endtask
  function automatic logic prot(input logic [1:0] cp, input logic [10:0] a);
    return cp == 2'h3 ? 1'b0 : cp == 2'h2 ? a >= 11'h400 : cp == 2'h1 ? a >= 11'h200 : 1'b1;
  endfunction
  // Power cycle, program a word early, then judge the time-out
  task automatic pwr_up(input logic [13:0] w);
    logic [13:0] rd;
    logic [10:0] ad[5];
    int lo;
    ad = '{11'h1ff, 11'h200, 11'h3ff, 11'h400, 11'h7ff};
    lo = POR + ((w[6] || !w[3]) ? POWERUP_DELAY_TIMER : 0) + ((w[1:0] != 2'h3) ? 4 * OSC_STARTUP_TIMER - 4 : 0);
    pm.pin(1'b0, 0);
    rst_n <= 1'b0;
    tick(20);
    rst_n <= 1'b1;
    pm.set_mode(1'b1);
    pm.word_write(`CWR_CFG_ADDR, w);
    pm.word_read(`CWR_CFG_ADDR, rd);
    chk(rd, w);
    pm.word_read(14'h2006, rd);
    chk(rd, 14'h0);
    pm.set_mode(1'b0);
    pm.word_read(`CWR_CFG_ADDR, rd);
    chk(rd, 14'h0);
    repeat (200) if (timeout_busy !== 1'b0) tick(1);
    chk({13'h0, (t_done - t_on) inside {[lo:lo + 14]}}, 14'h1);
    chk({12'h0, osc_mode}, {12'h0, w[1:0]});
    tick(4);
    chk({13'h0, device_reset_n}, 14'h0);
    pm.pin(1'b1, 0);
    tick(2);
    chk({13'h0, device_reset_n}, 14'h1);
    foreach (ad[i]) begin
      fetch_addr <= ad[i];
      tick(2);
      chk({13'h0, code_protected}, {13'h0, prot(w[5:4], ad[i])});
    end
    brownout_low <= 1'b1;
    tick(2);
    chk({13'h0, brownout_reset}, {13'h0, w[6]});
    brownout_low <= 1'b0;
    tick(2);
  endtask
  // Watchdog awake, asleep, cleared, and switched off
  task automatic wdog;
    int r0, w0;
    pwr_up(14'h3fbf);
    r0 = n_rst;
    rc(2);
    pls(3'h2);
    rc(2);
    chk(14'(n_rst - r0), 14'h0);
    rc(1);
    tick(4);
    chk(14'(n_rst - r0), 14'h1);
    pls(3'h4);
    chk({13'h0, sleeping}, 14'h1);
    w0 = n_wake;
    rc(3);
    chk(14'(n_wake - w0), 14'h1);
    chk({13'h0, sleeping}, 14'h0);
    pls(3'h4);
    pls(3'h1);
    chk({13'h0, sleeping}, 14'h0);
    pls(3'h4);
    pm.pin(1'b0, 0);
    tick(2);
    chk({13'h0, sleeping}, 14'h0);
    pwr_up(14'h3fbb);
    r0 = n_rst;
    rc(6);
    chk(14'(n_rst - r0), 14'h0);
  endtask
  initial begin
    foreach (tab[i]) pwr_up(tab[i]);
    wdog();
    results();
  end
endmodule
